// File: rtl/qusm_consts.svh
// constants of the quad serial channel select and modem block
// assumes inclusion by bare name from the package and the top module
`ifndef QUSM_CONSTS_SVH
`define QUSM_CONSTS_SVH

// ---------------------------------------------------------------
// register offsets inside one channel
// ---------------------------------------------------------------
`define QUSM_OFF_DATA 3'h0
`define QUSM_OFF_IER  3'h1
`define QUSM_OFF_ISR  3'h2
`define QUSM_OFF_LCR  3'h3
`define QUSM_OFF_MODEM_CTL  3'h4
`define QUSM_OFF_LSR        3'h5
`define QUSM_OFF_MODEM_STAT 3'h6

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define QUSM_CTL_DTR  0
`define QUSM_CTL_RTS  1
`define QUSM_CTL_OUT2 3
`define QUSM_CTL_LOOP 4
`define QUSM_LCR_PEN  3
`define QUSM_LCR_EPS  4
`define QUSM_IER_RX   0
`define QUSM_IER_THRE 1
`define QUSM_IER_LINE 2
`define QUSM_IER_MDM  3
`define QUSM_PIN_CTS  0
`define QUSM_PIN_DSR  4
`define QUSM_PIN_RING 8
`define QUSM_PIN_CARR 12
`define QUSM_PIN_RX   16
`define QUSM_PIN_MODE 20
`define QUSM_PIN_RST  21

// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define QUSM_OUT_IDLE 4'hF
`define QUSM_BITS_PAR 4'hB
`define QUSM_BITS_NOP 4'hA
`define QUSM_CLK_NS   4
`define QUSM_BIT_NS   64

`endif

// File: rtl/qusm_pkg.sv
// types of the quad serial channel select and modem block
// assumes the constants header sits beside it
`include "qusm_consts.svh"

package qusm_pkg;

	// receiver sequence of one channel
	typedef enum logic [1:0] {
		QUSM_RX_IDLE  = 2'b00,
		QUSM_RX_START = 2'b01,
		QUSM_RX_DATA  = 2'b10
	} qusm_rx_state_type;

	// whole state of the block, all four channels
	typedef struct packed {
		logic [21:0]                   sync1;
		logic [21:0]                   sync2;
		logic [3:0][4:0]               mctl;
		logic [3:0][3:0]               ier;
		logic [3:0][1:0]               lcr;
		logic [3:0]                    ring_prev;
		logic [3:0]                    teri;
		logic [3:0]                    tx_busy;
		logic [3:0][10:0]              tx_sh;
		logic [3:0][3:0]               tx_n;
		logic [3:0][15:0]              tx_cnt;
		qusm_rx_state_type [3:0]       rx_st;
		logic [3:0][9:0]               rx_sh;
		logic [3:0][3:0]               rx_n;
		logic [3:0][15:0]              rx_cnt;
		logic [3:0][7:0]               rhr;
		logic [3:0]                    rx_rdy;
		logic [3:0]                    par_err;
		logic [3:0]                    frm_err;
		logic [3:0]                    tx_q;
		logic [3:0]                    dtr_n;
		logic [3:0]                    rts_n;
		logic [3:0]                    int_q;
		logic                          irq_oe_n;
		logic [7:0]                    rdata;
		logic                          rvalid;
	} qusm_state_type;

endpackage

// File: rtl/qusm_top.sv
// four serial channels behind a selectable host bus front end
// assumes host strobes come from logic on i_clock; modem pins do not
//
// Summary of operation
// - bus mode pin high picks four selects, low picks select plus address
// - four-select mode: exactly one low select picks a channel, else none
// - single-select mode: select low, two address bits pick channels A-D
// - clear-to-send low means modem ready; shown in status bit 4
// - control bit 0 set drives terminal-ready low, clear drives it high
// - control bit 1 set drives request-to-send low, clear drives it high
// - request-to-send stays high after reset until software changes it
// - handshake pins never affect transmit or receive
// - ring indicator rising edge raises modem status interrupt if enabled
// - carrier-detect low means carrier present
// - transmit pin high in reset, idle and when transmitter is off
// - loop-back ignores receive pin and feeds transmit data to receiver
// - transmit frames with start, stop, optional parity; receive checks it
// - four-select mode: style input and control bit 3 shape interrupts
// - reset pin high-active in four-select mode, low-active otherwise
// - single-select mode merges interrupts onto one open-drain low request
`timescale 1ns/10ps
`include "qusm_consts.svh"

module qusm_top #(
	parameter int unsigned BIT_CYCLES = `QUSM_BIT_NS / `QUSM_CLK_NS
) (
	input  wire logic       i_clock,                // system clock
	input  wire logic       i_rst,                  // async reset, high
	input  wire logic       i_bus_mode,             // pin: 1 four selects
	input  wire logic       i_reset_pin,            // pin: mode-polar reset
	input  wire logic [3:0] i_channel_select_n,     // four selects, a..d
	input  wire logic       i_chip_select_n,        // single select
	input  wire logic [1:0] i_channel_addr,         // channel address bits
	input  wire logic [2:0] i_addr,                 // register offset
	input  wire logic       i_wr,                   // write strobe pulse
	input  wire logic       i_rd,                   // read strobe pulse
	input  wire logic [7:0] i_wdata,                // write data
	input  wire logic       i_interrupt_style_select, // 1 continuous
	input  wire logic [3:0] i_clear_to_send_n,      // pins, per channel
	input  wire logic [3:0] i_data_set_ready_n,     // pins, per channel
	input  wire logic [3:0] i_ring_indicator_n,     // pins, per channel
	input  wire logic [3:0] i_carrier_detect_n,     // pins, per channel
	input  wire logic [3:0] i_rx,                   // serial in pins
	output logic [3:0]      o_tx,                   // serial out pins
	output logic [3:0]      o_dtr_n,                // terminal ready
	output logic [3:0]      o_rts_n,                // request to send
	output logic [3:0]      o_int,                  // per channel interrupt
	output logic            o_irq_oe_n,             // low: pull request low
	output logic [7:0]      o_rdata,                // read data
	output logic            o_rvalid                // read data valid pulse
);
	import qusm_pkg::*;

	localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
	localparam logic [15:0] BIT_HALF = 16'(BIT_CYCLES / 2 - 1);

	// ---------------------------------------------------------------
	// elaboration check
	// ---------------------------------------------------------------
	if (BIT_CYCLES < 4 || BIT_CYCLES > 65536) begin : g_chk
		$error("BIT_CYCLES out of range");
	end

	// ---------------------------------------------------------------
	// functions
	// ---------------------------------------------------------------
	// one-hot channel pick; ambiguous selects pick nothing
	function automatic logic [3:0] qusm_chan_sel(input logic mode,
			input logic [3:0] sel_n, input logic cs_n,
			input logic [1:0] a);
		logic [3:0] r;
		r = 4'h0;
		if (mode) begin
			case (sel_n)
				4'hE: r = 4'h1;
				4'hD: r = 4'h2;
				4'hB: r = 4'h4;
				4'h7: r = 4'h8;
				default: r = 4'h0;
			endcase
		end else if (!cs_n) begin
			r = 4'h1 << a;
		end
		return r;
	endfunction

	// parity bit for even (eps) or odd
	function automatic logic qusm_par(input logic eps,
			input logic [7:0] d);
		return eps ? ^d : ~^d;
	endfunction

	function automatic qusm_state_type qusm_rst_state();
		qusm_state_type s;
		s = '0;
		s.dtr_n = `QUSM_OUT_IDLE;
		s.rts_n = `QUSM_OUT_IDLE;
		s.tx_q = `QUSM_OUT_IDLE;
		s.irq_oe_n = 1'b1;
		// idle pin level, so release of reset makes no false ring edge
		s.ring_prev = 4'hF;
		return s;
	endfunction

	qusm_state_type st;
	qusm_state_type nxt_st;
	logic           w_mode;
	logic           w_soft;
	logic [3:0]     w_sel;
	logic [3:0]     w_pend;

	// ---------------------------------------------------------------
	// decode and pending requests
	// ---------------------------------------------------------------
	assign w_mode = st.sync2[`QUSM_PIN_MODE];
	// polarity of the reset pin follows the bus mode
	assign w_soft = w_mode ? st.sync2[`QUSM_PIN_RST]
			: !st.sync2[`QUSM_PIN_RST];
	assign w_sel = qusm_chan_sel(w_mode, i_channel_select_n,
			i_chip_select_n, i_channel_addr);

	// enabled service needs of each channel
	always_comb begin
		w_pend = 4'h0;
		for (int i = 0; i < 4; i++) begin
			w_pend[i] = (st.ier[i][`QUSM_IER_RX] & st.rx_rdy[i])
				| (st.ier[i][`QUSM_IER_THRE] & !st.tx_busy[i])
				| (st.ier[i][`QUSM_IER_LINE]
					& (st.par_err[i] | st.frm_err[i]))
				| (st.ier[i][`QUSM_IER_MDM] & st.teri[i]);
		end
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic       txl;
		logic       line;
		logic       pen;
		logic [9:0] v;
		logic [7:0] d;
		txl = 1'b1;
		line = 1'b1;
		pen = 1'b0;
		v = 10'h000;
		d = 8'h00;
		nxt_st = st;
		nxt_st.sync1 = {i_reset_pin, i_bus_mode, i_rx, i_carrier_detect_n,
			i_ring_indicator_n, i_data_set_ready_n, i_clear_to_send_n};
		nxt_st.sync2 = st.sync1;
		nxt_st.rvalid = 1'b0;
		nxt_st.rdata = 8'h00;
		// channels are copies; none looks at another
		for (int i = 0; i < 4; i++) begin
			pen = st.lcr[i][0];
			// host reads first so that hardware sets win below
			if (w_sel[i] && i_rd) begin
				nxt_st.rvalid = 1'b1;
				case (i_addr)
					`QUSM_OFF_DATA: begin
						nxt_st.rdata = st.rhr[i];
						nxt_st.rx_rdy[i] = 1'b0;
					end
					`QUSM_OFF_IER: nxt_st.rdata = {4'h0, st.ier[i]};
					`QUSM_OFF_ISR: nxt_st.rdata = {4'h0, st.teri[i],
						st.par_err[i] | st.frm_err[i], !st.tx_busy[i],
						st.rx_rdy[i]};
					`QUSM_OFF_LCR: nxt_st.rdata = {3'h0, st.lcr[i], 3'h0};
					`QUSM_OFF_MODEM_CTL: nxt_st.rdata = {3'h0, st.mctl[i]};
					`QUSM_OFF_LSR: begin
						nxt_st.rdata = {1'b0, !st.tx_busy[i], !st.tx_busy[i],
							1'b0, st.frm_err[i], st.par_err[i], 1'b0,
							st.rx_rdy[i]};
						nxt_st.par_err[i] = 1'b0;
						nxt_st.frm_err[i] = 1'b0;
					end
					`QUSM_OFF_MODEM_STAT: begin
						nxt_st.rdata = {
							!st.sync2[`QUSM_PIN_CARR + i],
							!st.sync2[`QUSM_PIN_RING + i],
							!st.sync2[`QUSM_PIN_DSR + i],
							!st.sync2[`QUSM_PIN_CTS + i],
							1'b0, st.teri[i], 2'b00};
						nxt_st.teri[i] = 1'b0;
					end
					default: nxt_st.rdata = 8'h00;
				endcase
			end
			// host writes into the selected channel only
			if (w_sel[i] && i_wr) begin
				case (i_addr)
					`QUSM_OFF_IER: nxt_st.ier[i] = i_wdata[3:0];
					`QUSM_OFF_LCR: nxt_st.lcr[i] =
						{i_wdata[`QUSM_LCR_EPS], i_wdata[`QUSM_LCR_PEN]};
					`QUSM_OFF_MODEM_CTL: nxt_st.mctl[i] = i_wdata[4:0];
					default: ;
				endcase
			end
			// ring trailing edge: pin back to high
			nxt_st.ring_prev[i] = st.sync2[`QUSM_PIN_RING + i];
			if (!st.ring_prev[i] && st.sync2[`QUSM_PIN_RING + i]) begin
				nxt_st.teri[i] = 1'b1;
			end
			// transmitter; handshake pins take no part here
			txl = st.tx_busy[i] ? st.tx_sh[i][0] : 1'b1;
			if (st.tx_busy[i]) begin
				if (st.tx_cnt[i] == 16'h0000) begin
					nxt_st.tx_sh[i] = {1'b1, st.tx_sh[i][10:1]};
					nxt_st.tx_n[i] = st.tx_n[i] - 4'h1;
					nxt_st.tx_cnt[i] = BIT_LAST;
					if (st.tx_n[i] == 4'h1) begin
						nxt_st.tx_busy[i] = 1'b0;
					end
				end else begin
					nxt_st.tx_cnt[i] = st.tx_cnt[i] - 16'h0001;
				end
			end else if (w_sel[i] && i_wr && i_addr == `QUSM_OFF_DATA) begin
				// start bit low, optional parity, one stop bit
				nxt_st.tx_sh[i] = {1'b1,
					pen ? qusm_par(st.lcr[i][1], i_wdata) : 1'b1,
					i_wdata, 1'b0};
				nxt_st.tx_n[i] = pen ? `QUSM_BITS_PAR : `QUSM_BITS_NOP;
				nxt_st.tx_cnt[i] = BIT_LAST;
				nxt_st.tx_busy[i] = 1'b1;
			end
			// loop-back parks the pin high and feeds the receiver
			nxt_st.tx_q[i] = st.mctl[i][`QUSM_CTL_LOOP] ? 1'b1 : txl;
			line = st.mctl[i][`QUSM_CTL_LOOP] ? txl
				: st.sync2[`QUSM_PIN_RX + i];
			// receiver samples mid-bit
			case (st.rx_st[i])
				QUSM_RX_IDLE: begin
					if (!line) begin
						nxt_st.rx_st[i] = QUSM_RX_START;
						nxt_st.rx_cnt[i] = BIT_HALF;
					end
				end
				QUSM_RX_START: begin
					if (st.rx_cnt[i] != 16'h0000) begin
						nxt_st.rx_cnt[i] = st.rx_cnt[i] - 16'h0001;
					end else if (line) begin
						nxt_st.rx_st[i] = QUSM_RX_IDLE; // glitch, not a start
					end else begin
						nxt_st.rx_st[i] = QUSM_RX_DATA;
						nxt_st.rx_cnt[i] = BIT_LAST;
						nxt_st.rx_n[i] = pen ? `QUSM_BITS_PAR - 4'h1
							: `QUSM_BITS_NOP - 4'h1;
					end
				end
				QUSM_RX_DATA: begin
					if (st.rx_cnt[i] != 16'h0000) begin
						nxt_st.rx_cnt[i] = st.rx_cnt[i] - 16'h0001;
					end else begin
						v = {line, st.rx_sh[i][9:1]};
						nxt_st.rx_sh[i] = v;
						nxt_st.rx_cnt[i] = BIT_LAST;
						nxt_st.rx_n[i] = st.rx_n[i] - 4'h1;
						if (st.rx_n[i] == 4'h1) begin
							d = pen ? v[7:0] : v[8:1];
							nxt_st.rx_st[i] = QUSM_RX_IDLE;
							nxt_st.rhr[i] = d;
							nxt_st.rx_rdy[i] = 1'b1;
							if (pen && v[8] != qusm_par(st.lcr[i][1], d)) begin
								nxt_st.par_err[i] = 1'b1;
							end
							if (!line) begin
								nxt_st.frm_err[i] = 1'b1;
							end
						end
					end
				end
				default: nxt_st.rx_st[i] = QUSM_RX_IDLE;
			endcase
			// handshake outputs, active low
			nxt_st.dtr_n[i] = !st.mctl[i][`QUSM_CTL_DTR];
			nxt_st.rts_n[i] = !st.mctl[i][`QUSM_CTL_RTS];
			// software gated or continuous style
			nxt_st.int_q[i] = w_mode & (i_interrupt_style_select ? w_pend[i]
				: w_pend[i] & st.mctl[i][`QUSM_CTL_OUT2]);
		end
		// merged open-drain request in single-select mode
		nxt_st.irq_oe_n = !(!w_mode && (|w_pend));
		if (w_soft) begin
			nxt_st = qusm_rst_state();
			nxt_st.sync1 = {i_reset_pin, i_bus_mode, i_rx,
				i_carrier_detect_n, i_ring_indicator_n,
				i_data_set_ready_n, i_clear_to_send_n};
			nxt_st.sync2 = st.sync1;
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			st <= qusm_rst_state();
		end else begin
			st <= nxt_st;
		end
	end

	assign o_tx = st.tx_q;
	assign o_dtr_n = st.dtr_n;
	assign o_rts_n = st.rts_n;
	assign o_int = st.int_q;
	assign o_irq_oe_n = st.irq_oe_n;
	assign o_rdata = st.rdata;
	assign o_rvalid = st.rvalid;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	AST_SEL_FOUR: assert property (
		@(posedge i_clock) disable iff (i_rst)
		w_mode && $countones(~i_channel_select_n) != 1 |-> w_sel == 4'h0)
		else $error("four-select decode picked a channel");
	AST_SEL_ONE: assert property (
		@(posedge i_clock) disable iff (i_rst)
		!w_mode |-> w_sel == (i_chip_select_n ? 4'h0
			: 4'h1 << i_channel_addr))
		else $error("single-select decode wrong");
	AST_DTR: assert property (
		@(posedge i_clock) disable iff (i_rst || w_soft)
		w_sel[0] && i_wr && i_addr == `QUSM_OFF_MODEM_CTL ##1 !w_soft
		|=> o_dtr_n[0] == !$past(i_wdata[0], 2))
		else $error("terminal ready does not follow control bit 0");
	AST_RTS: assert property (
		@(posedge i_clock) disable iff (i_rst || w_soft)
		w_sel[1] && i_wr && i_addr == `QUSM_OFF_MODEM_CTL ##1 !w_soft
		|=> o_rts_n[1] == !$past(i_wdata[1], 2))
		else $error("request to send does not follow control bit 1");
	AST_RESET_OUT: assert property (
		@(posedge i_clock) disable iff (i_rst)
		w_soft |=> o_rts_n == 4'hF && o_dtr_n == 4'hF && o_tx == 4'hF)
		else $error("outputs not idle after pin reset");
	AST_STATUS_CTS: assert property (
		@(posedge i_clock) disable iff (i_rst || w_soft)
		w_sel[2] && i_rd && i_addr == `QUSM_OFF_MODEM_STAT
		|=> o_rvalid && o_rdata[4] == !$past(st.sync2[`QUSM_PIN_CTS + 2]))
		else $error("status bit 4 does not show clear to send");
	AST_TX_IDLE: assert property (
		@(posedge i_clock) disable iff (i_rst || w_soft)
		!st.tx_busy[0] |=> o_tx[0])
		else $error("transmit pin low while idle");
	AST_LOOP: assert property (
		@(posedge i_clock) disable iff (i_rst || w_soft)
		st.mctl[3][`QUSM_CTL_LOOP] [*2] |-> o_tx[3])
		else $error("transmit pin moved in loop-back");
	// channel d is the one whose ring edge is exercised in four-select mode
	AST_RING: assert property (
		@(posedge i_clock) disable iff (i_rst || w_soft)
		$rose(st.teri[3]) && st.ier[3][`QUSM_IER_MDM] && w_mode
		|=> o_int[3] == $past(i_interrupt_style_select
			|| st.mctl[3][`QUSM_CTL_OUT2]))
		else $error("ring edge interrupt wrong for its style");
	AST_IRQ_MERGE: assert property (
		@(posedge i_clock) disable iff (i_rst || w_soft)
		!w_mode && (|w_pend) ##1 !w_soft |-> !o_irq_oe_n && o_int == 4'h0)
		else $error("merged request not pulled low");

endmodule

// File: dv/qusm_modem_model.sv
// modem model facing the four serial channels of the block
// assumes the bench sets the wanted modem pin levels and owns the clock
`timescale 1ns/10ps

module qusm_modem_model #(
	parameter int ECHO = 3               // line delay in clock cycles
) (
	input  wire logic        i_clock,    // bench clock
	input  wire logic [15:0] i_pins,     // {carrier, ring, dsr, cts}, a..d
	input  wire logic [3:0]  i_tx,       // serial lines from the block
	output logic [3:0]       o_cts_n,    // clear to send, low = ready
	output logic [3:0]       o_dsr_n,    // data set ready
	output logic [3:0]       o_ring_indicator_n, // ring indicator
	output logic [3:0]       o_carrier_detect_n, // carrier detect
	output logic [3:0]       o_rx        // serial lines into the block
);

	// ---------------------------------------------------------------
	// modem handshake pins
	// ---------------------------------------------------------------
	// active low levels straight from the bench, no glitching here
	assign o_cts_n = i_pins[3:0];
	assign o_dsr_n = i_pins[7:4];
	assign o_ring_indicator_n = i_pins[11:8];
	assign o_carrier_detect_n = i_pins[15:12];

	// ---------------------------------------------------------------
	// echo line
	// ---------------------------------------------------------------
	// far end loops each channel back after a short cable delay
	// idle high from the start, one process drives the line
	logic [3:0] line [ECHO] = '{default: 4'hF};
	always @(posedge i_clock) begin
		line[0] <= i_tx;
		for (int i = 1; i < ECHO; i++) line[i] <= line[i - 1];
	end
	assign o_rx = line[ECHO - 1];

endmodule

// File: dv/quad_uart_channel_select_modem_test.sv
// self-checking bench of the quad channel select and modem block
// assumes the modem model echoes every serial line back to the block
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
	$display("mismatch %0t got %h exp %h", $time, g, e); end end

module quad_uart_channel_select_modem_test;

	// ---------------------------------------------------------------
	// stimulus and observation
	// ---------------------------------------------------------------
	logic        clk = 0, rst = 1, mode = 1, rpin = 0, csn = 1, sty = 0;
	logic        wr = 0, rd = 0, irq, rv, hi;
	logic [3:0]  seln = 4'hF, cts, dsr, ring_n, carr_n, rx, tx;
	logic [3:0]  dtr, rts, intr;
	logic [1:0]  ca = 2'h0;
	logic [2:0]  ad = 3'h0;
	logic [7:0]  wd = 8'h00, rdat, got, b;
	logic [15:0] pins = 16'hFFFF;
	logic [31:0] seed = 32'hF8D5;
	logic [10:0] fr;
	logic [7:0]  ctl_model [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
	int          failures = 0, comparisons = 0, cycles = 0;

	always #2 clk = ~clk;

	// cut a hang short well beyond the few hundred cycles needed
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			summarize();
		end
	end

	qusm_top #(.BIT_CYCLES(4)) dut (
		.i_clock(clk), .i_rst(rst), .i_bus_mode(mode), .i_reset_pin(rpin),
		.i_channel_select_n(seln), .i_chip_select_n(csn),
		.i_channel_addr(ca), .i_addr(ad), .i_wr(wr), .i_rd(rd),
		.i_wdata(wd), .i_interrupt_style_select(sty),
		.i_clear_to_send_n(cts), .i_data_set_ready_n(dsr),
		.i_ring_indicator_n(ring_n), .i_carrier_detect_n(carr_n),
		.i_rx(rx),
		.o_tx(tx), .o_dtr_n(dtr), .o_rts_n(rts), .o_int(intr),
		.o_irq_oe_n(irq), .o_rdata(rdat), .o_rvalid(rv)
	);

	qusm_modem_model u_modem (
		.i_clock(clk), .i_pins(pins), .i_tx(tx), .o_cts_n(cts),
		.o_dsr_n(dsr), .o_ring_indicator_n(ring_n),
		.o_carrier_detect_n(carr_n), .o_rx(rx)
	);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// channel 0-3, 4 none picked, 5 two selects low at once
	task automatic pick(input int ch);
		seln <= (ch == 5) ? 4'hC : (mode && ch < 4) ? ~(4'h1 << ch) : 4'hF;
		csn <= (mode || ch > 3);
		ca <= ch[1:0];
	endtask

	// one strobe; read data taken just after the edge that launches it,
	// since valid stands for that one cycle only
	task automatic bus(input int ch, input logic [2:0] a,
			input logic [7:0] d, input logic w);
		@(posedge clk);
		pick(ch);
		ad <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		wr <= 0;
		rd <= 0;
		pick(4);
		#1;
		got = rdat;
		if (w && a == 3'h4 && ch < 4) ctl_model[ch] = d;
		`CHK(rv, (!w && ch < 4))
	endtask

	// modem outputs follow control bits two edges after the write
	task automatic pins_ok;
		repeat (3) @(posedge clk);
		#1;
		for (int i = 0; i < 4; i++) begin
			`CHK(dtr[i], ~ctl_model[i][0])
			`CHK(rts[i], ~ctl_model[i][1])
		end
	endtask

	// random control writes, including unselected and double selects
	task automatic rnd_writes;
		for (int k = 0; k < 12; k++) begin
			seed = lfsr(seed);
			bus(k % 6, 3'h4, seed[7:0] & 8'h07, 1'b1);
			pins_ok();
		end
	endtask

	// ring edge on one channel with the modem interrupt enabled
	task automatic ring(input int ch);
		bus(ch, 3'h1, 8'h08, 1'b1);
		@(posedge clk);
		pins <= pins & ~(16'h0100 << ch);
		repeat (6) @(posedge clk);
		pins <= pins | (16'h0100 << ch);
		repeat (8) @(posedge clk);
		#1;
	endtask

	task automatic summarize;
		if (failures == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		repeat (6) @(posedge clk);
		#1;
		`CHK(tx, 4'hF)
		`CHK(rts, 4'hF)
		`CHK(dtr, 4'hF)
		`CHK(intr, 4'h0)
		`CHK(irq, 1'b1)
		rnd_writes();
		// random modem levels, ring kept high so no edge is made
		seed = lfsr(seed);
		@(posedge clk);
		pins <= seed[15:0] | 16'h0F00;
		repeat (4) @(posedge clk);
		for (int c = 0; c < 4; c++) begin
			bus(c, 3'h6, 8'h00, 1'b0);
			`CHK(got, {~pins[12 + c], ~pins[8 + c], ~pins[4 + c], ~pins[c], 4'h0})
		end
		`CHK(tx, 4'hF)
		// interrupt style in four-select mode, channel d
		ring(3);
		`CHK(intr, 4'h0)
		bus(3, 3'h4, 8'h08, 1'b1);
		pins_ok();
		`CHK(intr, 4'h8)
		@(posedge clk);
		sty <= 1;
		bus(3, 3'h4, 8'h00, 1'b1);
		pins_ok();
		`CHK(intr, 4'h8)
		`CHK(irq, 1'b1)
		bus(3, 3'h6, 8'h00, 1'b0);
		`CHK(got[2], 1'b1)
		repeat (3) @(posedge clk);
		#1;
		`CHK(intr, 4'h0)
		// single-select mode, reset pin now active low
		@(posedge clk);
		mode <= 0;
		rpin <= 1;
		sty <= 0;
		repeat (6) @(posedge clk);
		rnd_writes();
		ring(2);
		`CHK(irq, 1'b0)
		`CHK(intr, 4'h0)
		bus(2, 3'h6, 8'h00, 1'b0);
		`CHK(got[2], 1'b1)
		repeat (3) @(posedge clk);
		#1;
		`CHK(irq, 1'b1)
		// even parity frame on channel a, echoed back by the modem
		seed = lfsr(seed);
		b = seed[7:0];
		fr = {1'b1, ^b, b, 1'b0};
		bus(0, 3'h3, 8'h18, 1'b1);
		bus(0, 3'h0, b, 1'b1);
		repeat (3) @(posedge clk);
		#1;
		for (int j = 0; j < 11; j++) begin
			`CHK(tx[0], fr[j])
			repeat (4) @(posedge clk);
			#1;
		end
		repeat (20) @(posedge clk);
		bus(0, 3'h0, 8'h00, 1'b0);
		`CHK(got, b)
		bus(0, 3'h5, 8'h00, 1'b0);
		`CHK(got, 8'h60)
		// loop-back on channel b keeps the pin idle
		seed = lfsr(seed);
		b = seed[7:0];
		bus(1, 3'h4, 8'h10, 1'b1);
		bus(1, 3'h3, 8'h00, 1'b1);
		bus(1, 3'h0, b, 1'b1);
		hi = 1;
		repeat (70) begin
			@(posedge clk);
			#1;
			hi &= tx[1];
		end
		`CHK(hi, 1'b1)
		bus(1, 3'h0, 8'h00, 1'b0);
		`CHK(got, b)
		// pin reset returns the modem outputs to idle
		@(posedge clk);
		rpin <= 0;
		repeat (5) @(posedge clk);
		#1;
		`CHK(dtr, 4'hF)
		`CHK(rts, 4'hF)
		summarize();
	end

endmodule
